// ---- bench/tb_top.sv ----
/*
  Self-checking bench of the clock frequency monitor: band, stop detect, refusals.
  Assumes rtl/ is on the include path and the package is compiled first.
*/
`timescale 1ns/1ps
`include "cfm_consts.svh"
module tb_top;
  import cfm_pkg::*;
  logic                 clock_in, rst_in, ext_ref, err_clr, ovf_clr, nmi_clr;
  logic [`CFM_NOSC-1:0] osc_in;
  cfm_cfg_t             cfg;
  logic                 err_irq, ovf_irq, nmi, mid_sel, err_prev, nmi_prev;
  cfm_status_t          status;
  int                   failures, checked, cyc;
  int                   per [0:7];
  int                   ph [0:7];
  logic [31:0]          rng;
  logic [3:0]           notes [$];

  cfm_monitor dut (.clock_in(clock_in), .rst_in(rst_in), .osc_in(osc_in),
    .external_reference_input_in(ext_ref), .cfg_in(cfg), .err_clear_in(err_clr),
    .ovf_clear_in(ovf_clr), .nmi_clear_in(nmi_clr), .freq_err_irq_out(err_irq),
    .overflow_irq_out(ovf_irq), .nmi_out(nmi), .mid_osc_select_out(mid_sel),
    .status_out(status));

  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  // Phases keep target and reference edges apart, so a window holds an exact count.
  always @(posedge clock_in) begin : osc_gen
    logic [7:0] lv;
    for (int s = 0; s < 8; s++) lv[s] = (per[s] != 0) && (((cyc + ph[s]) % per[s]) < per[s] / 2);
    cyc    <= cyc + 1;
    osc_in <= lv[6:0];
    ext_ref <= lv[7];
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic pop_cmp(input logic kind, input logic [2:0] got);
    logic [3:0] n;
    if (notes.size() == 0) begin
      failures++;
      $display("BAD %0t unexpected event %0d", $time, kind);
    end else begin
      n = notes.pop_front();
      chk({kind, got}, n, "event");
    end
  endtask

  always @(negedge clock_in) begin
    if (!rst_in && status.freq_err_flag === 1'b1 && err_prev !== 1'b1)
      pop_cmp(1'b0, {err_irq, ovf_irq, status.ovf_flag});
    if (!rst_in && nmi === 1'b1 && nmi_prev !== 1'b1)
      pop_cmp(1'b1, {nmi, status.oscillation_stop_flag, mid_sel});
    err_prev <= status.freq_err_flag;
    nmi_prev <= nmi;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  task automatic measure(input cfm_src_t t, input cfm_src_t r, input logic [15:0] e,
                         input logic ie);
    @(posedge clock_in);
    cfg.measure_enable <= 1'b0;
    for (int s = 0; s < 8; s++) begin
      rng = xs(rng);
      per[s] <= 6 + int'(rng % 15);
      ph[s]  <= 0;
    end
    per[t] <= 10;
    ph[t]  <= 5;
    per[r] <= 100;
    cfg.target_sel     <= t;
    cfg.ref_sel        <= r;
    cfg.expected_count <= e;
    cfg.err_irq_enable <= ie;
    tick(6);
    cfg.measure_enable <= 1'b1;
  endtask

  task automatic clear_err();
    @(posedge clock_in);
    cfg.measure_enable <= 1'b0;
    err_clr <= 1'b1;
    @(posedge clock_in);
    err_clr <= 1'b0;
    tick(2);
  endtask

  task automatic final_report();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #(40 * 40000);
    failures++;
    $display("BAD %0t watchdog expired", $time);
    final_report();
  end

  initial begin : main
    logic [15:0] bnd [4];
    bnd = '{16'h0024, 16'h0025, 16'h002C, 16'h002D};
    rng = 32'h438106B4; cyc = 0; rst_in = 1'b1; osc_in = '0; ext_ref = 1'b0; cfg = '0;
    err_clr = 1'b0; ovf_clr = 1'b0; nmi_clr = 1'b0;
    for (int s = 0; s < 8; s++) begin per[s] = 12; ph[s] = 0; end
    cfg.ovf_irq_enable = 1'b1;
    tick(16);
    rst_in <= 1'b0;
    tick(2);
    chk({err_irq, ovf_irq, nmi, mid_sel}, 16'h0000, "reset outputs");
    $display("test reset done");
    // Every target against a different reference; 10-cycle target over 400 cycles.
    for (int t = 0; t < 7; t++) begin
      measure(cfm_src_t'(t), cfm_src_t'(t + 1), 16'h0028, 1'b1);
      tick(1100);
      chk(status.last_count, 16'h0028, "count");
      chk(status.freq_err_flag, 1'b0, "in band");
    end
    $display("test sources done");
    // Band edges: 36 and 45 put 40 just outside, 37 and 44 just inside.
    for (int i = 0; i < 4; i++) begin
      measure(CFM_SRC_HIGH, CFM_SRC_MAIN, bnd[i], i[1]);
      if (i == 0 || i == 3) notes.push_back({1'b0, i[1], 2'b00});
      tick(1100);
      chk(status.freq_err_flag, (i == 0 || i == 3), "band edge");
      chk(status.ovf_flag, 1'b0, "no overflow");
      clear_err();
      chk(err_irq, 1'b0, "irq cleared");
    end
    $display("test band done");
    measure(CFM_SRC_EXT, CFM_SRC_MAIN, 16'h0028, 1'b1);
    tick(600);
    chk(status.measuring, 1'b0, "external pin refused as target");
    $display("test refusal done");
    cfg.measure_enable <= 1'b0;
    per[0] <= 10;
    cfg.stop_detect_enable <= 1'b1;
    tick(200);
    chk({nmi, mid_sel}, 16'h0000, "main running");
    per[0] <= 0;
    notes.push_back(4'b1111);
    tick(44);
    chk(nmi, 1'b0, "too early");
    for (int i = 0; i < 40 && notes.size() != 0; i++) @(posedge clock_in);
    chk(notes.size(), 16'h0000, "stop event seen");
    nmi_clr <= 1'b1;
    tick(1);
    nmi_clr <= 1'b0;
    per[0] <= 10;
    tick(200);
    chk({nmi, mid_sel}, 16'h0001, "switch holds");
    rst_in <= 1'b1;
    tick(4);
    rst_in <= 1'b0;
    tick(2);
    chk(mid_sel, 1'b0, "second reset");
    $display("test stop done");
    final_report();
  end
endmodule // tb_top

// ---- rtl/cfm_consts.svh ----
/*
  Constants of the clock frequency monitor: widths, limits and timing counts.
  Assumes a 25 MHz system clock on clock_in.
*/
`ifndef CFM_CONSTS_SVH
`define CFM_CONSTS_SVH
`define CFM_NSRC          8
`define CFM_NOSC          7
`define CFM_CNT_W         16
`define CFM_TOL_PERCENT   10
`define CFM_PERCENT_BASE  100
`define CFM_CLK_PERIOD_NS 40
`define CFM_STOP_TIME_NS  2000
`define CFM_STOP_CYCLES   ((`CFM_STOP_TIME_NS + `CFM_CLK_PERIOD_NS - 1) / `CFM_CLK_PERIOD_NS)
`define CFM_STOP_W        8
`define CFM_REF_EDGES     4
`define CFM_WIN_W         8
`endif

// ---- rtl/cfm_edge_sync.sv ----
/*
  Two flip-flop synchroniser with a rising edge detector behind it.
  Assumes async_in is a clock or level from outside the clock_in domain.
*/
`timescale 1ns/1ps
module cfm_edge_sync (
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic async_in,
  output logic      rise_out
);
  logic meta;
  logic sync;
  logic prev;
  logic next_rise;

  // The first stage feeds only the second one to keep metastability contained.
  always_comb begin
    next_rise = sync & ~prev;
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      meta     <= 1'b0;
      sync     <= 1'b0;
      prev     <= 1'b0;
      rise_out <= 1'b0;
    end else begin
      meta     <= async_in;
      sync     <= meta;
      prev     <= sync;
      rise_out <= next_rise;
    end
  end
endmodule // cfm_edge_sync

// ---- rtl/cfm_monitor.sv ----
/*
  Clock frequency monitor: counts target clock edges over a window of reference edges,
  checks the count against a tolerance band and watches the main oscillator for a stop.
  Assumes all monitored clocks are well below half of clock_in, since they are sampled.
*/
// Contract
// R1: Reference is any oscillator, watchdog, peripheral clock or the external reference pin.
// R2: Target is any oscillator, watchdog clock or peripheral clock.
// R3: A count outside the allowed band raises frequency error or overflow.
// R4: Each interrupt reaches its output only while its enable is set.
// R5: Band is expected count plus or minus a percentage, default ten.
// R6: A stopped main oscillator switches the system to the middle-speed oscillator.
// R7: An oscillator stop raises the NMI and sets the stop flag.
// R8: Target edges are counted per reference window; a counter wrap means overflow.
`timescale 1ns/1ps
`include "cfm_consts.svh"
module cfm_monitor #(
  parameter int TOL_PERCENT = `CFM_TOL_PERCENT,
  parameter int REF_EDGES   = `CFM_REF_EDGES
) (
  input  wire logic                    clock_in,
  input  wire logic                    rst_in,
  input  wire logic [`CFM_NOSC-1:0]    osc_in,
  input  wire logic                    external_reference_input_in,
  input  wire cfm_pkg::cfm_cfg_t       cfg_in,
  input  wire logic                    err_clear_in,
  input  wire logic                    ovf_clear_in,
  input  wire logic                    nmi_clear_in,
  output logic                         freq_err_irq_out,
  output logic                         overflow_irq_out,
  output logic                         nmi_out,
  output logic                         mid_osc_select_out,
  output cfm_pkg::cfm_status_t         status_out
);
  import cfm_pkg::*;

  logic [`CFM_NSRC-1:0]   src_raw;
  logic [`CFM_NSRC-1:0]   src_rise;
  logic                   tgt_rise;
  logic                   ref_rise;
  cfm_state_t             st;
  cfm_state_t             next_st;
  logic [`CFM_WIN_W-1:0]  win;
  logic [`CFM_WIN_W-1:0]  next_win;
  logic [`CFM_CNT_W-1:0]  tgt_cnt;
  logic [`CFM_CNT_W-1:0]  next_tgt_cnt;
  logic                   wrap;
  logic                   next_wrap;
  logic [`CFM_CNT_W-1:0]  last_count;
  logic [`CFM_CNT_W-1:0]  next_last_count;
  logic [`CFM_CNT_W:0]    upper;
  logic [`CFM_CNT_W:0]    next_upper;
  logic [`CFM_CNT_W-1:0]  lower;
  logic [`CFM_CNT_W-1:0]  next_lower;
  logic [31:0]            delta;
  logic                   err_evt;
  logic                   ovf_evt;
  logic                   err_flag;
  logic                   next_err_flag;
  logic                   ovf_flag;
  logic                   next_ovf_flag;
  logic [`CFM_STOP_W-1:0] stop_cnt;
  logic [`CFM_STOP_W-1:0] next_stop_cnt;
  logic                   main_stopped;
  logic                   next_main_stopped;
  logic                   stop_evt;
  logic                   stop_flag;
  logic                   next_stop_flag;
  logic                   next_err_irq;
  logic                   next_ovf_irq;
  logic                   measuring;
  logic                   next_measuring;

  assign src_raw = {external_reference_input_in, osc_in};

  genvar g;
  generate
    for (g = 0; g < `CFM_NSRC; g++) begin : g_sync
      cfm_edge_sync u_sync (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .async_in (src_raw[g]),
        .rise_out (src_rise[g])
      );
    end
  endgenerate

  // The external pin can only be a reference; a target selection of it never starts.
  assign ref_rise = src_rise[cfg_in.ref_sel]; // see R1
  assign tgt_rise = src_rise[cfg_in.target_sel]; // see R2

  // Limits are held in flip-flops so the wide multiply stays off the compare path.
  always_comb begin
    delta      = ({16'h0000, cfg_in.expected_count} * 32'(TOL_PERCENT)) / `CFM_PERCENT_BASE;
    next_upper = (`CFM_CNT_W+1)'({16'h0000, cfg_in.expected_count} + delta); // see R5
    if (delta[`CFM_CNT_W-1:0] > cfg_in.expected_count) begin
      next_lower = '0;
    end else begin
      next_lower = cfg_in.expected_count - delta[`CFM_CNT_W-1:0]; // see R5
    end
  end

  always_comb begin
    next_st         = st;
    next_win        = win;
    next_tgt_cnt    = tgt_cnt;
    next_wrap       = wrap;
    next_last_count = last_count;
    err_evt         = 1'b0;
    ovf_evt         = 1'b0;
    case (st)
      CFM_IDLE: begin
        if (cfg_in.measure_enable && cfg_in.target_sel != CFM_SRC_EXT) begin // see R2
          next_st = CFM_ARM;
        end
      end
      CFM_ARM: begin
        if (!cfg_in.measure_enable) begin
          next_st = CFM_IDLE;
        end else if (ref_rise) begin // see R1
          next_st      = CFM_COUNT;
          next_win     = '0;
          next_tgt_cnt = '0;
          next_wrap    = 1'b0;
        end
      end
      CFM_COUNT: begin
        if (!cfg_in.measure_enable) begin
          next_st = CFM_IDLE;
        end else begin
          if (tgt_rise) begin
            next_tgt_cnt = tgt_cnt + 1'b1; // see R8
            if (&tgt_cnt) begin
              next_wrap = 1'b1; // see R8
            end
          end
          if (ref_rise) begin
            if (win == (`CFM_WIN_W)'(REF_EDGES - 1)) begin
              next_st = CFM_CHECK;
            end else begin
              next_win = win + 1'b1;
            end
          end
        end
      end
      CFM_CHECK: begin
        next_last_count = tgt_cnt;
        next_st         = CFM_ARM;
        if (wrap) begin
          ovf_evt = 1'b1; // see R3
        end else if ({1'b0, tgt_cnt} > upper || tgt_cnt < lower) begin
          err_evt = 1'b1; // see R3
        end
      end
      default: next_st = CFM_IDLE;
    endcase
    next_measuring = (next_st != CFM_IDLE);
  end

  // A flag being set in the cycle software clears it stays set.
  always_comb begin
    next_err_flag = (err_flag & ~err_clear_in) | err_evt;
    next_ovf_flag = (ovf_flag & ~ovf_clear_in) | ovf_evt;
    next_err_irq  = next_err_flag & cfg_in.err_irq_enable; // see R4
    next_ovf_irq  = next_ovf_flag & cfg_in.ovf_irq_enable; // see R4
  end

  // The switch to the middle-speed oscillator holds until reset, because a main clock
  // that comes back once has already proven unreliable.
  always_comb begin
    next_stop_cnt     = stop_cnt;
    next_main_stopped = main_stopped;
    stop_evt          = 1'b0;
    if (!cfg_in.stop_detect_enable || src_rise[CFM_SRC_MAIN]) begin
      next_stop_cnt = '0;
    end else if (!main_stopped) begin
      if (stop_cnt == (`CFM_STOP_W)'(`CFM_STOP_CYCLES - 1)) begin
        next_main_stopped = 1'b1; // see R6
        stop_evt          = 1'b1;
      end else begin
        next_stop_cnt = stop_cnt + 1'b1;
      end
    end
    next_stop_flag = (stop_flag & ~nmi_clear_in) | stop_evt; // see R7
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st                 <= CFM_IDLE;
      win                <= '0;
      tgt_cnt            <= '0;
      wrap               <= 1'b0;
      last_count         <= '0;
      upper              <= '0;
      lower              <= '0;
      err_flag           <= 1'b0;
      ovf_flag           <= 1'b0;
      freq_err_irq_out   <= 1'b0;
      overflow_irq_out   <= 1'b0;
      stop_cnt           <= '0;
      main_stopped       <= 1'b0;
      stop_flag          <= 1'b0;
      nmi_out            <= 1'b0;
      mid_osc_select_out <= 1'b0;
      measuring          <= 1'b0;
    end else begin
      st                 <= next_st;
      win                <= next_win;
      tgt_cnt            <= next_tgt_cnt;
      wrap               <= next_wrap;
      last_count         <= next_last_count;
      upper              <= next_upper;
      lower              <= next_lower;
      err_flag           <= next_err_flag;
      ovf_flag           <= next_ovf_flag;
      freq_err_irq_out   <= next_err_irq;
      overflow_irq_out   <= next_ovf_irq;
      stop_cnt           <= next_stop_cnt;
      main_stopped       <= next_main_stopped;
      stop_flag          <= next_stop_flag;
      nmi_out            <= next_stop_flag; // see R7
      mid_osc_select_out <= next_main_stopped; // see R6
      measuring          <= next_measuring;
    end
  end

  assign status_out = '{measuring: measuring, freq_err_flag: err_flag,
                        ovf_flag: ovf_flag, oscillation_stop_flag: stop_flag,
                        last_count: last_count};

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  AST_REF_STARTS: assert property ((st == CFM_ARM && cfg_in.measure_enable && ref_rise)
    |=> (st == CFM_COUNT && tgt_cnt == '0 && !wrap)) else $error("Window did not open."); // see R1
  AST_EXT_NOT_TARGET: assert property ((st == CFM_IDLE && cfg_in.target_sel == CFM_SRC_EXT)
    |=> st == CFM_IDLE) else $error("External pin used as target."); // see R2
  AST_ERR_RAISED: assert property ((st == CFM_CHECK && !wrap && tgt_cnt < lower)
    |=> status_out.freq_err_flag) else $error("Low count not flagged."); // see R3
  AST_ERR_GATED: assert property (freq_err_irq_out
    |-> $past(cfg_in.err_irq_enable)) else $error("Error irq while disabled."); // see R4
  AST_OVF_GATED: assert property ($rose(overflow_irq_out)
    |-> $past(cfg_in.ovf_irq_enable) && status_out.ovf_flag) else $error("Overflow irq bad."); // see R4
  AST_BAND: assert property ((cfg_in.expected_count == 16'h0028) [*2]
    |-> upper == 17'h0002C && lower == 16'h0024) else $error("Band wrong for 40."); // see R5
  AST_SWITCH_MID: assert property ($rose(main_stopped)
    |-> mid_osc_select_out ##1 mid_osc_select_out) else $error("No switch to mid osc."); // see R6
  AST_NMI_SET: assert property (stop_evt
    |=> nmi_out && status_out.oscillation_stop_flag) else $error("Stop without NMI."); // see R7
  AST_WRAP_OVF: assert property ((st == CFM_COUNT && cfg_in.measure_enable && tgt_rise
    && &tgt_cnt) |=> wrap && tgt_cnt == '0) else $error("Wrap lost."); // see R8
  AST_OVF_FLAG: assert property ((st == CFM_CHECK && wrap)
    |=> status_out.ovf_flag && !$rose(status_out.freq_err_flag)) else $error("No ovf."); // see R8

  CVR_ERROR: cover property (err_evt);
  CVR_OVERFLOW: cover property (ovf_evt);
  CVR_STOP: cover property (stop_evt);
  CVR_PASS: cover property (st == CFM_CHECK && !err_evt && !ovf_evt);
endmodule // cfm_monitor

// ---- rtl/cfm_pkg.sv ----
/*
  Types of the clock frequency monitor: clock source codes, configuration and status.
  Assumes cfm_consts.svh is on the include path.
*/
`include "cfm_consts.svh"
package cfm_pkg;
  typedef enum logic [2:0] {
    CFM_SRC_MAIN, CFM_SRC_SUB, CFM_SRC_HIGH, CFM_SRC_MID,
    CFM_SRC_LOW, CFM_SRC_WDT, CFM_SRC_PERIPHERAL_CLOCK_B, CFM_SRC_EXT
  } cfm_src_t;

  typedef enum logic [1:0] {CFM_IDLE, CFM_ARM, CFM_COUNT, CFM_CHECK} cfm_state_t;

  typedef struct packed {
    logic                   measure_enable;
    logic                   err_irq_enable;
    logic                   ovf_irq_enable;
    logic                   stop_detect_enable;
    cfm_src_t               target_sel;
    cfm_src_t               ref_sel;
    logic [`CFM_CNT_W-1:0]  expected_count;
  } cfm_cfg_t;

  typedef struct packed {
    logic                   measuring;
    logic                   freq_err_flag;
    logic                   ovf_flag;
    logic                   oscillation_stop_flag;
    logic [`CFM_CNT_W-1:0]  last_count;
  } cfm_status_t;
endpackage
